// ### include/cle_pkg.sv
// shared constants and types of the character display instruction engine
`default_nettype none
package cle_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ      = 20;
	localparam int T_CLEAR_NS   = 1520000;
	localparam int T_EXEC_NS    = 37000;
	localparam int T_SHIFT_NS   = 56000;
	localparam int T_DREAD_NS   = 56000;
	localparam int T_INIT_NS    = 10000000;
	localparam int T_RSTLOW_NS  = 1200000;
	// least times, rounded up to whole cycles
	localparam int CYC_CLEAR    = (T_CLEAR_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_EXEC     = (T_EXEC_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_SHIFT    = (T_SHIFT_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_DREAD    = (T_DREAD_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_INIT     = (T_INIT_NS * CLK_MHZ + 999) / 1000;
	localparam int CYC_RSTLOW   = (T_RSTLOW_NS * CLK_MHZ + 999) / 1000;
	localparam int TMR_W        = 18;
	typedef logic [TMR_W-1:0] cle_tmr_t;

	// ****************************************
	// memory layout and reset values
	// ****************************************
	localparam int         TEXT_DEPTH  = 128;
	localparam int         GLYPH_DEPTH = 32;
	localparam logic [6:0] AC_RESET    = 7'h00;
	localparam logic [6:0] AC_LAST     = 7'h7f;
	localparam logic [6:0] LINE2_BASE  = 7'h40;
	localparam logic [3:0] HALF_CHARS  = 4'h8;
	localparam logic [7:0] BLANK_CHAR  = 8'h20;
	localparam logic [7:0] CMD_CLEAR   = 8'h01;

	// ****************************************
	// register map of the apb side
	// ****************************************
	localparam logic [11:0] OFF_CTRL   = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_SHIFT  = 12'h008;
	localparam int          CTRL_INIT  = 0;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		MODE_RUN   = 2'b00,
		MODE_CLEAR = 2'b01
	} cle_mode_e;

	typedef struct packed {
		logic       rs;
		logic       rw;
		logic       en;
		logic [7:0] db;
	} cle_hbus_s;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} cle_apb_s;

	typedef struct packed {
		logic inc;
		logic shift_en;
		logic disp_on;
		logic cur_on;
		logic blink_on;
		logic bus_width_select;
		logic amode;
		logic line_format_select;
		logic pin_config_select;
	} cle_cfg_s;

	localparam cle_cfg_s CFG_INIT = '{inc: 1'b1, bus_width_select: 1'b1, default: 1'b0};

	typedef struct packed {
		cle_mode_e   mode;
		cle_cfg_s    cfg;
		logic [6:0]  address_counter;
		logic        cg_sel;
		logic [6:0]  shift;
		logic        en_q;
		logic        nib;
		logic [3:0]  hi;
		logic        rpin_q;
		logic [15:0] rlow_cnt;
		logic        por_pend;
		logic [6:0]  clr_addr;
		logic [7:0]  db;
		logic        db_oe_n;
		logic        busy;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic [7:0]  scan;
	} cle_state_s;

endpackage
`default_nettype wire

// ### core/cle_busy_timer.sv
// down counter that holds the busy flag for one execution time
`timescale 1ns/1ps
`default_nettype none
module cle_busy_timer (
	input  wire logic              clock_i,
	input  wire logic              srst_i,
	input  wire logic              load_i,
	input  wire cle_pkg::cle_tmr_t val_i,
	output logic                   busy_o
);
	cle_pkg::cle_tmr_t cnt_r;
	cle_pkg::cle_tmr_t cnt_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		if (load_i) begin
			cnt_nxt = val_i;
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - cle_pkg::cle_tmr_t'(1);
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign busy_o = (cnt_r != '0);

	load_then_busy_a: assert property (@(posedge clock_i) disable iff (srst_i)
		load_i && val_i != '0 |=> busy_o) else $error("timer idle after load");
endmodule
`default_nettype wire

// ### core/cle_engine.sv
// instruction engine of the character display controller with host bus and apb
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R01 - register select picks instruction/status (low) or data (high) register
// R02 - host never sends the all-zero instruction; it is ignored here
// R03 - code 01 blanks text ram, address counter to zero, busy 1.52 ms
// R04 - return home zeroes address counter and display shift, ram untouched
// R05 - entry mode latches increment/decrement and shift-on-access
// R06 - display control latches display, cursor and blink enables
// R07 - shift instruction moves cursor or display left or right
// R08 - function set latches bus width and addressing mode
// R09 - function set also latches line format and pin configuration
// R10 - glyph address instruction loads counter, data goes to glyph ram
// R11 - text address instruction loads counter, data goes to text ram
// R12 - status read returns busy flag and address counter at once
// R13 - busy high while executing; host waits for it low
// R14 - data write stores byte in text ram or five bits in glyph ram
// R15 - data read returns text byte or five glyph bits, busy 56 us
// R16 - after power-up run initialisation holding busy for 10 ms
// R17 - reset pin low longer than 1.2 ms runs full reset sequence
// R18 - reset pin going low reports busy for 10 ms
// R19 - without automatic init the host initialises by instructions
// R20 - positions 1-8 show 00h-07h, positions 9-16 show 40h-47h
// R21 - 4-bit mode moves bytes as high nibble then low nibble
// R22 - host drives select and direction; enable falling edge qualifies
// R23 - instruction decoded from its highest set bit
// R24 - each data access steps counter and applies configured shift
// R25 - busy held for each instruction's execution time then cleared
module cle_engine #(
	parameter int CLEAR_CYC  = cle_pkg::CYC_CLEAR,
	parameter int INIT_CYC   = cle_pkg::CYC_INIT,
	parameter int RSTLOW_CYC = cle_pkg::CYC_RSTLOW
) (
	input  wire logic                clock_i,
	input  wire logic                srst_i,
	input  wire cle_pkg::cle_hbus_s  hbus_i,
	input  wire logic                hw_reset_n_i,
	output logic [7:0]               db_o,
	output logic                     db_oe_n_o,
	output logic                     busy_o,
	input  wire logic [3:0]          scan_pos_i,
	output logic [7:0]               scan_char_o,
	output cle_pkg::cle_cfg_s        cfg_o,
	input  wire cle_pkg::cle_apb_s   apb_i,
	output logic [31:0]              prdata_o,
	output logic                     pready_o,
	output logic                     pslverr_o
);
	// ****************************************
	// state
	// ****************************************
	cle_pkg::cle_state_s st_r;
	cle_pkg::cle_state_s st_nxt;

	logic [7:0] text_ram [cle_pkg::TEXT_DEPTH];
	logic [4:0] glyph_ram [cle_pkg::GLYPH_DEPTH];

	logic              tmr_busy;
	logic              tmr_load;
	cle_pkg::cle_tmr_t tmr_val;
	logic              busy_now;
	logic              fall;
	logic              complete;
	logic              wr_done;
	logic              rd_done;
	logic              ins_ok;
	logic              dat_ok;
	logic [7:0]        byte_w;
	logic [7:0]        rd_byte;
	logic              t_we;
	logic [6:0]        t_wa;
	logic [7:0]        t_wd;
	logic              g_we;
	logic              start_init;
	logic              apb_wr;
	logic [6:0]        scan_addr;

	function automatic logic [6:0] step(input logic [6:0] a, input logic inc, input logic cg);
		logic [6:0] n;
		n = inc ? a + 7'h01 : a - 7'h01;
		return cg ? {2'b00, n[4:0]} : n;
	endfunction

	cle_busy_timer u_timer (
		.clock_i (clock_i),
		.srst_i  (srst_i),
		.load_i  (tmr_load),
		.val_i   (tmr_val),
		.busy_o  (tmr_busy)
	);

	// ****************************************
	// host bus decode
	// ****************************************
	// clear sweep, a held reset pin and a pending power-up count as busy too
	assign busy_now = tmr_busy | (st_r.mode == cle_pkg::MODE_CLEAR) | ~st_r.rpin_q
		| st_r.por_pend; // R13
	assign fall     = st_r.en_q & ~hbus_i.en; // R22
	assign complete = st_r.cfg.bus_width_select | st_r.nib; // R21
	assign byte_w   = st_r.cfg.bus_width_select ? hbus_i.db : {st_r.hi, hbus_i.db[7:4]}; // R21
	assign wr_done  = fall & complete & ~hbus_i.rw;
	assign rd_done  = fall & complete & hbus_i.rw;
	// commands arriving while busy are dropped rather than queued
	assign ins_ok   = wr_done & ~hbus_i.rs & ~busy_now; // R01
	assign dat_ok   = fall & complete & hbus_i.rs & ~busy_now; // R01
	assign apb_wr   = apb_i.psel & apb_i.penable & apb_i.pwrite & st_r.pready;

	always_comb begin
		if (~hbus_i.rs) begin
			rd_byte = {busy_now, st_r.address_counter}; // R12
		end else if (st_r.cg_sel) begin
			rd_byte = {3'h0, glyph_ram[st_r.address_counter[4:0]]}; // R15
		end else begin
			rd_byte = text_ram[st_r.address_counter]; // R15
		end
	end

	// line split of the single row, offset by the display shift
	always_comb begin
		if (scan_pos_i < cle_pkg::HALF_CHARS) begin
			scan_addr = {3'h0, scan_pos_i}; // R20
		end else begin
			scan_addr = cle_pkg::LINE2_BASE + {3'h0, scan_pos_i - cle_pkg::HALF_CHARS}; // R20
		end
		scan_addr = scan_addr + st_r.shift;
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_nxt     = st_r;
		tmr_load   = 1'b0;
		tmr_val    = '0;
		t_we       = 1'b0;
		t_wa       = st_r.address_counter;
		t_wd       = byte_w;
		g_we       = 1'b0;
		start_init = 1'b0;

		st_nxt.en_q     = hbus_i.en;
		st_nxt.rpin_q   = hw_reset_n_i;
		st_nxt.busy     = busy_now;
		st_nxt.por_pend = 1'b0;
		st_nxt.scan     = st_r.cfg.disp_on ? text_ram[scan_addr] : cle_pkg::BLANK_CHAR;

		// read drive, high nibble first in 4-bit mode
		st_nxt.db_oe_n = ~(hbus_i.en & hbus_i.rw);
		if (complete & ~st_r.cfg.bus_width_select) begin
			st_nxt.db = {rd_byte[3:0], 4'h0}; // R21
		end else begin
			st_nxt.db = rd_byte;
		end

		if (fall & ~st_r.cfg.bus_width_select) begin
			st_nxt.nib = ~st_r.nib; // R21
			if (~st_r.nib) begin
				st_nxt.hi = hbus_i.db[7:4];
			end
		end

		if (ins_ok) begin
			casez (byte_w) // R23
				8'b1???????: begin
					st_nxt.address_counter = byte_w[6:0]; // R11
					st_nxt.cg_sel          = 1'b0;
					tmr_load               = 1'b1;
					tmr_val                = cle_pkg::cle_tmr_t'(cle_pkg::CYC_EXEC);
				end
				8'b01??????: begin
					// glyph address is five bits; bit 5 is a don't-care position
					st_nxt.address_counter = {2'b00, byte_w[4:0]}; // R10
					st_nxt.cg_sel          = 1'b1;
					tmr_load               = 1'b1;
					tmr_val                = cle_pkg::cle_tmr_t'(cle_pkg::CYC_EXEC);
				end
				8'b001?????: begin
					st_nxt.cfg.bus_width_select   = byte_w[4]; // R08
					st_nxt.cfg.amode              = byte_w[3];
					st_nxt.cfg.line_format_select = byte_w[1]; // R09
					st_nxt.cfg.pin_config_select  = byte_w[0];
					st_nxt.nib                    = 1'b0;
					tmr_load                      = 1'b1;
					tmr_val                       = cle_pkg::cle_tmr_t'(cle_pkg::CYC_EXEC);
				end
				8'b0001????: begin
					if (byte_w[3]) begin
						st_nxt.shift = byte_w[2] ? st_r.shift + 7'h01 : st_r.shift - 7'h01; // R07
					end else begin
						st_nxt.address_counter = step(st_r.address_counter, byte_w[2],
							st_r.cg_sel); // R07
					end
					tmr_load = 1'b1;
					tmr_val  = cle_pkg::cle_tmr_t'(cle_pkg::CYC_SHIFT); // R25
				end
				8'b00001???: begin
					st_nxt.cfg.disp_on  = byte_w[2]; // R06
					st_nxt.cfg.cur_on   = byte_w[1];
					st_nxt.cfg.blink_on = byte_w[0];
					tmr_load            = 1'b1;
					tmr_val             = cle_pkg::cle_tmr_t'(cle_pkg::CYC_EXEC);
				end
				8'b000001??: begin
					st_nxt.cfg.inc      = byte_w[1]; // R05
					st_nxt.cfg.shift_en = byte_w[0];
					tmr_load            = 1'b1;
					tmr_val             = cle_pkg::cle_tmr_t'(cle_pkg::CYC_EXEC);
				end
				8'b0000001?: begin
					st_nxt.address_counter = cle_pkg::AC_RESET; // R04
					st_nxt.cg_sel          = 1'b0;
					st_nxt.shift           = '0;
					tmr_load               = 1'b1;
					tmr_val                = cle_pkg::cle_tmr_t'(cle_pkg::CYC_EXEC); // R25
				end
				8'b00000001: begin
					st_nxt.address_counter = cle_pkg::AC_RESET; // R03
					st_nxt.cg_sel          = 1'b0;
					st_nxt.mode            = cle_pkg::MODE_CLEAR;
					st_nxt.clr_addr        = '0;
					tmr_load               = 1'b1;
					tmr_val                = cle_pkg::cle_tmr_t'(CLEAR_CYC); // R03
				end
				default: begin
					// factory test code: no effect
					st_nxt.mode = st_r.mode; // R02
				end
			endcase
		end

		if (dat_ok) begin
			if (~hbus_i.rw) begin
				t_we     = ~st_r.cg_sel; // R14
				g_we     = st_r.cg_sel;
				tmr_val  = cle_pkg::cle_tmr_t'(cle_pkg::CYC_EXEC);
			end else begin
				tmr_val  = cle_pkg::cle_tmr_t'(cle_pkg::CYC_DREAD); // R15
			end
			tmr_load = 1'b1;
			st_nxt.address_counter = step(st_r.address_counter, st_r.cfg.inc,
				st_r.cg_sel); // R24
			if (st_r.cfg.shift_en) begin
				st_nxt.shift = st_r.cfg.inc ? st_r.shift + 7'h01 : st_r.shift - 7'h01; // R24
			end
		end

		// clear sweep, one text location per cycle
		if (st_r.mode == cle_pkg::MODE_CLEAR) begin
			t_we            = 1'b1; // R03
			t_wa            = st_r.clr_addr;
			t_wd            = cle_pkg::BLANK_CHAR;
			st_nxt.clr_addr = st_r.clr_addr + 7'h01;
			if (st_r.clr_addr == cle_pkg::AC_LAST) begin
				st_nxt.mode = cle_pkg::MODE_RUN;
			end
		end

		// reset pin: busy from the falling edge, full sequence after the low time
		if (~hw_reset_n_i) begin
			if (st_r.rpin_q) begin
				tmr_load = 1'b1; // R18
				tmr_val  = cle_pkg::cle_tmr_t'(INIT_CYC);
			end
			if (st_r.rlow_cnt != 16'(RSTLOW_CYC)) begin
				st_nxt.rlow_cnt = st_r.rlow_cnt + 16'h0001;
			end
			if (st_r.rlow_cnt == 16'(RSTLOW_CYC - 1)) begin
				start_init = 1'b1; // R17
			end
		end else begin
			st_nxt.rlow_cnt = '0;
		end

		// apb slave, one wait state per access
		st_nxt.pready  = apb_i.psel & apb_i.penable & ~st_r.pready;
		st_nxt.pslverr = 1'b0;
		st_nxt.prdata  = '0;
		if (apb_i.psel & apb_i.penable & ~st_r.pready) begin
			case (apb_i.paddr)
				cle_pkg::OFF_CTRL: st_nxt.prdata = '0;
				cle_pkg::OFF_STATUS: st_nxt.prdata = {12'h000, st_r.mode, st_r.cfg,
					st_r.cg_sel, busy_now, st_r.address_counter};
				cle_pkg::OFF_SHIFT: st_nxt.prdata = {25'h0000000, st_r.shift};
				default: st_nxt.pslverr = 1'b1;
			endcase
		end

		// power-up or software request: the supply-good event is the reset release
		if (st_r.por_pend | (apb_wr & (apb_i.paddr == cle_pkg::OFF_CTRL)
				& apb_i.pwdata[cle_pkg::CTRL_INIT])) begin
			start_init = 1'b1;
			tmr_load   = 1'b1; // R16
			tmr_val    = cle_pkg::cle_tmr_t'(INIT_CYC);
		end

		if (start_init) begin
			st_nxt.cfg             = cle_pkg::CFG_INIT;
			st_nxt.address_counter = cle_pkg::AC_RESET;
			st_nxt.cg_sel          = 1'b0;
			st_nxt.shift           = '0;
			st_nxt.nib             = 1'b0;
			st_nxt.mode            = cle_pkg::MODE_CLEAR;
			st_nxt.clr_addr        = '0;
		end
	end

	// ****************************************
	// registers and memories
	// ****************************************
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			st_r          <= '0;
			st_r.cfg      <= cle_pkg::CFG_INIT;
			st_r.por_pend <= 1'b1;
			st_r.rpin_q   <= 1'b1;
			st_r.db_oe_n  <= 1'b1;
			st_r.busy     <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ram has no reset; the init sweep blanks the text
	always_ff @(posedge clock_i) begin
		if (t_we) begin
			text_ram[t_wa] <= t_wd; // R14
		end
		if (g_we) begin
			glyph_ram[st_r.address_counter[4:0]] <= byte_w[4:0]; // R14
		end
	end

	assign db_o        = st_r.db;
	assign db_oe_n_o   = st_r.db_oe_n;
	assign busy_o      = st_r.busy;
	assign scan_char_o = st_r.scan;
	assign cfg_o       = st_r.cfg;
	assign prdata_o    = st_r.prdata;
	assign pready_o    = st_r.pready;
	assign pslverr_o   = st_r.pslverr;

	// ****************************************
	// assertions
	// ****************************************
	default clocking @(posedge clock_i); endclocking
	default disable iff (srst_i);

	clear_busy_a: assert property (ins_ok && byte_w == cle_pkg::CMD_CLEAR && hw_reset_n_i |=> // R03
		st_r.address_counter == cle_pkg::AC_RESET ##1 busy_o) else $error("clear not busy");
	home_zero_a: assert property (ins_ok && byte_w[7:1] == 7'h01 && hw_reset_n_i |=> // R04
		st_r.address_counter == '0 && st_r.shift == '0) else $error("home not zeroed");
	entry_latch_a: assert property (ins_ok && byte_w[7:2] == 6'h01 && hw_reset_n_i |=> // R05
		st_r.cfg.inc == $past(byte_w[1]) && st_r.cfg.shift_en == $past(byte_w[0]))
		else $error("entry mode lost");
	disp_latch_a: assert property (ins_ok && byte_w[7:3] == 5'h01 && hw_reset_n_i |=> // R06
		st_r.cfg.disp_on == $past(byte_w[2]) && st_r.cfg.blink_on == $past(byte_w[0]))
		else $error("display control lost");
	shift_move_a: assert property (ins_ok && byte_w[7:3] == 5'h03 && hw_reset_n_i |=> // R07
		st_r.shift == 7'($past(st_r.shift) + ($past(byte_w[2]) ? 7'h01 : 7'h7f)))
		else $error("display shift wrong");
	func_set_a: assert property (ins_ok && byte_w[7:5] == 3'h1 && hw_reset_n_i |=> // R08
		st_r.cfg.bus_width_select == $past(byte_w[4])
		&& st_r.cfg.line_format_select == $past(byte_w[1])) else $error("function set lost");
	text_addr_a: assert property (ins_ok && byte_w[7] && hw_reset_n_i |=> // R11
		st_r.address_counter == $past(byte_w[6:0]) && !st_r.cg_sel) else $error("address lost");
	status_read_a: assert property (hbus_i.en && hbus_i.rw && !hbus_i.rs // R12
		&& st_r.cfg.bus_width_select |=> !db_oe_n_o && db_o[6:0] == $past(st_r.address_counter))
		else $error("status read wrong");
	data_write_a: assert property (dat_ok && !hbus_i.rw && !st_r.cg_sel && hw_reset_n_i |=> // R14
		text_ram[$past(st_r.address_counter)] == $past(byte_w) && st_r.address_counter ==
		step($past(st_r.address_counter), st_r.cfg.inc, 1'b0)) else $error("data write lost");
	pin_busy_a: assert property (st_r.rpin_q && !hw_reset_n_i |-> ##2 busy_o [*8]) // R18
		else $error("reset pin not busy");
endmodule
`default_nettype wire

// ### bench/cle_host_model.sv
// behavioural host processor on the parallel instruction bus
`timescale 1ns/1ps
`default_nettype none
module cle_host_model (
	input  wire logic              clock_i,
	input  wire logic              four_bit_i,
	input  wire logic [7:0]        db_i,
	input  wire logic              db_oe_n_i,
	output var cle_pkg::cle_hbus_s hbus_o
);
	int stuck = 0;
	initial begin
		hbus_o = '0;
	end
	// ****************************************
	// bus cycles
	// ****************************************
	// read data only counts while the engine really drives the lines
	task automatic strobe(input logic rs, input logic rw, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clock_i);
		hbus_o <= '{rs: rs, rw: rw, en: 1'b1, db: rw ? ~hbus_o.db : d};
		repeat (3) @(posedge clock_i);
		q = (db_oe_n_i === 1'b0) ? db_i : 8'hxx;
		hbus_o.en <= 1'b0;
		repeat (2) @(posedge clock_i);
	endtask
	task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
		output logic [7:0] q);
		logic [7:0] a;
		logic [7:0] b;
		if (four_bit_i) begin
			strobe(rs, rw, {d[7:4], 4'h0}, a);
			strobe(rs, rw, {d[3:0], 4'h0}, b);
			q = {a[7:4], b[7:4]};
		end else begin
			strobe(rs, rw, d, q);
		end
	endtask
	// bounded poll, so a stuck flag ends in a failed wait, not a hang
	task automatic wait_idle(output logic ok);
		logic [7:0] s;
		int         n;
		n = 0;
		s = 8'hff;
		while (s[7] !== 1'b0 && n < 400) begin
			xfer(1'b0, 1'b1, 8'h00, s);
			n++;
		end
		ok = (s[7] === 1'b0);
		if (!ok) begin
			stuck++;
		end
	endtask
	task automatic acc(input logic rs, input logic rw, input logic [7:0] d,
		output logic [7:0] q);
		logic ok;
		wait_idle(ok);
		if (rs || rw || d != 8'h00) begin
			xfer(rs, rw, d, q);
		end
	endtask
endmodule
`default_nettype wire

// ### bench/char_lcd_instruction_engine_tb.sv
// self-checking bench for the instruction engine with a modelled host
`timescale 1ns/1ps
`default_nettype none
module char_lcd_instruction_engine_tb;
	localparam int CLR_C = 200;
	localparam int INI_C = 300;
	localparam int RLO_C = 20;
	localparam int EX    = cle_pkg::CYC_EXEC;
	localparam int SH    = cle_pkg::CYC_SHIFT;
	logic               clock_i      = 1'b0;
	logic               srst_i       = 1'b1;
	logic               hw_reset_n_i = 1'b1;
	logic               four_bit     = 1'b0;
	logic [3:0]         scan_pos     = 4'h0;
	cle_pkg::cle_apb_s  apb_r        = '0;
	cle_pkg::cle_hbus_s hbus;
	cle_pkg::cle_cfg_s  cfg_o;
	logic [7:0]         db_o;
	logic [7:0]         scan_char_o;
	logic [31:0]        prdata_o;
	logic               db_oe_n_o;
	logic               busy_o;
	logic               pready_o;
	logic               pslverr_o;
	int                 err_count    = 0;
	int                 comparisons  = 0;

	always #25 clock_i = ~clock_i;

	cle_engine #(.CLEAR_CYC(CLR_C), .INIT_CYC(INI_C), .RSTLOW_CYC(RLO_C)) uut (
		.clock_i(clock_i), .srst_i(srst_i), .hbus_i(hbus), .hw_reset_n_i(hw_reset_n_i),
		.db_o(db_o), .db_oe_n_o(db_oe_n_o), .busy_o(busy_o), .scan_pos_i(scan_pos),
		.scan_char_o(scan_char_o), .cfg_o(cfg_o), .apb_i(apb_r), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o));
	cle_host_model host (.clock_i(clock_i), .four_bit_i(four_bit), .db_i(db_o),
		.db_oe_n_i(db_oe_n_o), .hbus_o(hbus));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		@(posedge clock_i);
		apb_r <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
		@(posedge clock_i);
		apb_r.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (pready_o !== 1'b1) begin
			err_count++;
		end
		rd = prdata_o;
		er = pslverr_o;
		apb_r <= '0;
	endtask
	task automatic put(input logic rs, input logic [7:0] c);
		logic [7:0] q;
		host.acc(rs, 1'b0, c, q);
		repeat (4) @(posedge clock_i);
	endtask
	task automatic stat(input string nm, input logic [7:0] e);
		logic [7:0] s;
		logic       ok;
		host.wait_idle(ok);
		host.xfer(1'b0, 1'b1, 8'h00, s);
		chk(nm, s, e);
	endtask
	// busy length is judged in a window: the launch edge is not seen exactly
	task automatic timed(input logic rs, input logic rw, input logic [7:0] d, input int lo,
		input int hi, output logic [7:0] q);
		int n;
		host.acc(rs, rw, d, q);
		n = 0;
		while (busy_o !== 1'b1 && n < 8) begin
			@(posedge clock_i);
			n++;
		end
		n = 0;
		while (busy_o === 1'b1 && n <= hi) begin
			@(posedge clock_i);
			n++;
		end
		chk("busy_len", n >= lo && n <= hi, 1'b1);
	endtask
	task automatic pos(input logic [3:0] p, input logic [7:0] e);
		scan_pos <= p;
		repeat (3) @(posedge clock_i);
		chk("scan_char", scan_char_o, e);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_power();
		logic ok;
		chk("rst_busy", busy_o, 1'b1);
		chk("rst_oe", db_oe_n_o, 1'b1);
		chk("rst_cfg", cfg_o, cle_pkg::CFG_INIT);
		repeat (INI_C - 20) @(posedge clock_i);
		chk("init_busy", busy_o, 1'b1);
		host.wait_idle(ok);
		chk("init_done", ok, 1'b1);
		stat("init_status", 8'h00);
	endtask
	task automatic t_apb();
		logic [31:0] rd;
		logic        er;
		logic        ok;
		apb(1'b0, cle_pkg::OFF_STATUS, 32'h0, rd, er);
		chk("status_word", rd, {14'h0000, cle_pkg::CFG_INIT, 9'h000});
		apb(1'b0, 12'h00c, 32'h0, rd, er);
		chk("unmapped_err", er, 1'b1);
		chk("unmapped_data", rd, 32'h0);
		apb(1'b1, cle_pkg::OFF_CTRL, 32'h1, rd, er);
		repeat (4) @(posedge clock_i);
		chk("restart_busy", busy_o, 1'b1);
		host.wait_idle(ok);
		chk("restart_idle", ok, 1'b1);
	endtask
	task automatic t_cfg();
		put(1'b0, 8'h0f);
		chk("dcb_on", {cfg_o.disp_on, cfg_o.cur_on, cfg_o.blink_on}, 3'b111);
		put(1'b0, 8'h0a);
		chk("dcb_mix", {cfg_o.disp_on, cfg_o.cur_on, cfg_o.blink_on}, 3'b010);
		put(1'b0, 8'h05);
		chk("entry_dec", {cfg_o.inc, cfg_o.shift_en}, 2'b01);
		put(1'b0, 8'h06);
		chk("entry_inc", {cfg_o.inc, cfg_o.shift_en}, 2'b10);
		put(1'b0, 8'h3b);
		chk("fset_all", cfg_o[3:0], 4'b1111);
		put(1'b0, 8'h31);
		chk("fset_pin", cfg_o[3:0], 4'b1001);
		put(1'b0, 8'h3e);
		chk("fset_line", cfg_o[3:0], 4'b1110);
		put(1'b0, 8'h30);
	endtask
	task automatic t_data();
		logic [7:0] q;
		put(1'b0, 8'h85);
		stat("ac_load", 8'h05);
		timed(1'b1, 1'b0, 8'h41, EX - 4, EX + 4, q);
		stat("ac_up", 8'h06);
		put(1'b0, 8'h04);
		put(1'b0, 8'h85);
		timed(1'b1, 1'b1, 8'h00, SH - 4, SH + 4, q);
		chk("text_read", q, 8'h41);
		stat("ac_down", 8'h04);
		put(1'b0, 8'h06);
		put(1'b0, 8'h63);
		timed(1'b1, 1'b0, 8'hea, EX - 4, EX + 4, q);
		stat("glyph_ac", 8'h04);
		put(1'b0, 8'h43);
		host.acc(1'b1, 1'b1, 8'h00, q);
		chk("glyph_read", q[4:0], 5'h0a);
	endtask
	task automatic t_shift();
		logic [31:0] rd;
		logic        er;
		logic [7:0]  q;
		put(1'b0, 8'h92);
		timed(1'b0, 1'b0, 8'h14, SH - 4, SH + 4, q);
		stat("cur_right", 8'h13);
		put(1'b0, 8'h13);
		stat("cur_left", 8'h12);
		put(1'b0, 8'h1f);
		apb(1'b0, cle_pkg::OFF_SHIFT, 32'h0, rd, er);
		chk("disp_shift", rd[6:0] != 7'h00, 1'b1);
		stat("shift_keeps_ac", 8'h12);
		put(1'b0, 8'h03);
		stat("home_ac", 8'h00);
		apb(1'b0, cle_pkg::OFF_SHIFT, 32'h0, rd, er);
		chk("home_shift", rd, 32'h0);
	endtask
	task automatic t_map();
		logic [7:0] q;
		put(1'b0, 8'h0c);
		put(1'b0, 8'h87);
		put(1'b1, 8'h48);
		put(1'b1, 8'h5a);
		put(1'b0, 8'hc0);
		put(1'b1, 8'h49);
		pos(4'h5, 8'h41);
		pos(4'h7, 8'h48);
		pos(4'h8, 8'h49);
		put(1'b0, 8'h89);
		timed(1'b0, 1'b0, 8'h01, CLR_C - 4, CLR_C + 140, q);
		stat("clear_ac", 8'h00);
		pos(4'h7, 8'h20);
		put(1'b0, 8'h08);
		put(1'b0, 8'h87);
		put(1'b1, 8'h48);
		pos(4'h7, 8'h20);
	endtask
	task automatic t_four();
		logic [7:0] q;
		put(1'b0, 8'h28);
		four_bit <= 1'b1;
		@(posedge clock_i);
		chk("width4", cfg_o.bus_width_select, 1'b0);
		put(1'b0, 8'hc5);
		stat("nibble_status", 8'h45);
		put(1'b1, 8'h5c);
		put(1'b0, 8'hc5);
		host.acc(1'b1, 1'b1, 8'h00, q);
		chk("nibble_data", q, 8'h5c);
		put(1'b0, 8'h38);
		four_bit <= 1'b0;
		chk("width8", cfg_o.bus_width_select, 1'b1);
	endtask
	task automatic t_hwrst();
		logic ok;
		put(1'b0, 8'h0c);
		hw_reset_n_i <= 1'b0;
		repeat (5) @(posedge clock_i);
		hw_reset_n_i <= 1'b1;
		repeat (INI_C - 20) @(posedge clock_i);
		chk("pin_busy", busy_o, 1'b1);
		host.wait_idle(ok);
		chk("short_keeps", cfg_o.disp_on, 1'b1);
		hw_reset_n_i <= 1'b0;
		repeat (RLO_C + 10) @(posedge clock_i);
		chk("low_busy", busy_o, 1'b1);
		hw_reset_n_i <= 1'b1;
		host.wait_idle(ok);
		chk("long_resets", cfg_o, cle_pkg::CFG_INIT);
	endtask

	initial begin
		repeat (80000) @(posedge clock_i);
		err_count++;
		stop_test();
	end
	initial begin
		repeat (8) @(posedge clock_i);
		srst_i <= 1'b0;
		@(posedge clock_i);
		t_power();
		t_apb();
		t_cfg();
		t_data();
		t_shift();
		t_map();
		t_four();
		t_hwrst();
		chk("host_waits", host.stuck, 32'h0);
		stop_test();
	end
endmodule
`default_nettype wire
